// ### hw/op_decoder_map.vh
// constants for the byte-op instruction decoder and its register bus
// How it works
// RULE1 - low byte file address, bit8 bank, bit9 destination
// RULE2 - destination zero selects accumulator, else file
// RULE3 - bank bit zero means access bank
// RULE4 - file move: two words, 12-bit addresses
// RULE5 - bit ops: opcode, bit position, bank, address
// RULE6 - literal ops take low byte immediate
// RULE7 - call/jump target: 20 bits over two words
// RULE8 - call first word carries fast-mode bit
// RULE9 - relative jump carries 11-bit offset
// RULE10 - conditional branches carry 8-bit offset
// RULE11 - add ops: one cycle, five flags
// RULE12 - logic ops update only zero, negative
// RULE13 - subtract ops update all five flags
// RULE14 - inc/dec update flags; skip variants none
// RULE15 - compare/test skip, no flag change
// RULE16 - rotates and swap with their flag sets
// RULE17 - multiply: one cycle, no flags
// RULE18 - port read-modify-write uses pin levels
// RULE19 - timer-zero write clears assigned prescaler
// RULE20 - pc change or true test: two cycles; code: every skip two, a branch two only on condition 2 with carry
// RULE21 - unconsumed second word executes as no-op
// RULE22 - relative offsets are signed, added to pc
// RULE23 - product split into high, low bytes
`ifndef OP_DECODER_MAP_VH
`define OP_DECODER_MAP_VH

// register byte offsets
`define REG_INSN      5'h00
`define REG_CTRL      5'h04
`define REG_PC        5'h08
`define REG_DECODE    5'h0C
`define REG_FILE_ADDR 5'h10
`define REG_OPERAND   5'h14
`define REG_TARGET    5'h18
`define REG_STATUS    5'h1C

// control register fields
`define CTRL_BANK_LO  0
`define CTRL_BANK_HI  3
`define CTRL_PSA_BIT  4
`define CTRL_CARRY    5

// timer-zero and port file addresses (12 bit), access-bank split byte and high bank
`define TIMER_ZERO_ADDR 12'hFD6
`define PORT_BASE_ADDR  12'hF80
`define PORT_TOP_ADDR   12'hF88
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF

// op classes
`define CLS_NOP    4'h0
`define CLS_ALU    4'h1
`define CLS_SKIP   4'h2
`define CLS_MOVE   4'h3
`define CLS_BIT    4'h4
`define CLS_LIT    4'h5
`define CLS_JUMP   4'h6
`define CLS_CALL   4'h7
`define CLS_RJMP   4'h8
`define CLS_BRANCH 4'h9
`define CLS_MUL    4'hA
`define CLS_SECOND 4'hB

// flag mask bits: c dc z ov n
`define FL_NONE 5'h00
`define FL_ZN   5'h05
`define FL_CZN  5'h15
`define FL_ALL  5'h1F

`define PREFIX_MOVE   4'hC
`define PREFIX_SECOND 4'hF
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ### hw/op_decoder.v
// byte-oriented instruction decoder with an axi4-lite register file
`timescale 1ns/1ps
`default_nettype none
`include "op_decoder_map.vh"
module op_decoder (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] port_pins,
    input wire [4:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [4:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output reg prescaler_clear
);

////////////////////////////////////////////////////////////////////////////////
// register file
reg [15:0] insn;
reg [7:0] ctrl;
reg [20:0] pc;
reg insn_go;
reg aw_held;
reg w_held;
reg [4:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire do_write = aw_held && w_held && !bvalid;

assign awready = !aw_held && !bvalid;
assign wready = !w_held && !bvalid;
assign arready = !rvalid;

// decode outputs
reg [3:0] cls;
reg [5:0] op6;
reg dest_file;
reg bank_sel;
reg [11:0] file_addr;
reg [7:0] operand;
reg [20:0] target;
reg [4:0] flag_mask;
reg [2:0] bit_pos;
reg fast_mode;
reg [1:0] cycles;
reg rmw_port;
reg second_pending;
reg [11:0] move_src;
reg [7:0] prod_hi;
reg [7:0] prod_lo;
reg [7:0] acc;

// combinational decode of the word just loaded
reg [3:0] next_cls;
reg [4:0] next_flags;
reg next_dest;
reg [11:0] next_addr;
reg [7:0] next_operand;
reg [20:0] next_target;
reg [1:0] next_cycles;
reg next_rmw;
reg [11:0] bank_addr;
wire [3:0] top = insn[15:12];
wire [5:0] hi6 = insn[15:10];
wire [6:0] hi7 = insn[15:9];

always @* begin
    next_cls = `CLS_NOP;
    next_flags = `FL_NONE;
    next_dest = 1'b0;
    next_operand = insn[7:0];
    next_target = pc;
    next_cycles = 2'h1;
    next_rmw = 1'b0;
    // RULE3 bank select
    if (insn[8]) begin
        bank_addr = {ctrl[`CTRL_BANK_HI:`CTRL_BANK_LO], insn[7:0]};
    end else if (insn[7:0] < `ACCESS_SPLIT) begin
        bank_addr = {4'h0, insn[7:0]};
    end else begin
        bank_addr = {`ACCESS_HI_BANK, insn[7:0]};
    end
    // RULE1 file address field
    next_addr = bank_addr;
    if (second_pending) begin
        // RULE4 destination word of the move
        if (top == `PREFIX_SECOND) begin
            next_cls = `CLS_MOVE;
            next_addr = insn[11:0];
            next_cycles = 2'h2;
        end
    end else if (top == `PREFIX_SECOND) begin
        // RULE21 stray second word is a no-op
        next_cls = `CLS_SECOND;
    end else if (top == `PREFIX_MOVE) begin
        next_cls = `CLS_SECOND;
        next_addr = insn[11:0];
        next_cycles = 2'h2;
    end else if (top[3] && top != 4'hD && top != 4'hE) begin
        // RULE5 bit-oriented fields
        next_cls = `CLS_BIT;
        next_rmw = (top != 4'hB) && (top != 4'hA);
        if (!next_rmw) next_cycles = 2'h2;
    end else if (top == 4'hD) begin
        // RULE9 RULE22 signed 11-bit offset
        next_cls = `CLS_RJMP;
        next_target = pc + 21'h2 + {{9{insn[10]}}, insn[10:0], 1'b0};
        next_cycles = 2'h2;
    end else if (insn[15:9] == 7'h76 || insn[15:8] == 8'hEF) begin
        // RULE7 RULE8 call/jump low byte, fast bit in call
        next_cls = (insn[15:9] == 7'h76) ? `CLS_CALL : `CLS_JUMP;
        next_target = {13'h0, insn[7:0]};
        next_cycles = 2'h2;
    end else if (insn[15:11] == 5'h1C) begin
        // RULE10 RULE22 conditional 8-bit offset
        next_cls = `CLS_BRANCH;
        next_target = pc + 21'h2 + {{12{insn[7]}}, insn[7:0], 1'b0};
        next_cycles = (insn[10:8] == 3'h2 && ctrl[`CTRL_CARRY]) ? 2'h2 : 2'h1;
    end else if (insn[15:12] == 4'h0 && insn[11]) begin
        // RULE6 literal low byte
        next_cls = `CLS_LIT;
    end else if (hi7 == 7'h01) begin
        // RULE17 multiply, no flags
        next_cls = `CLS_MUL;
    end else if (hi6 == 6'h09 || hi6 == 6'h08) begin
        // RULE11 add ops
        next_cls = `CLS_ALU;
        next_flags = `FL_ALL;
    end else if (hi6 == 6'h05 || hi6 == 6'h04 || hi6 == 6'h07) begin
        // RULE12 logic ops
        next_cls = `CLS_ALU;
        next_flags = `FL_ZN;
    end else if (hi6 == 6'h17 || hi6 == 6'h16 || hi6 == 6'h15) begin
        // RULE13 subtract ops
        next_cls = `CLS_ALU;
        next_flags = `FL_ALL;
    end else if (hi6 == 6'h0A || hi6 == 6'h01) begin
        // RULE14 inc/dec
        next_cls = `CLS_ALU;
        next_flags = `FL_ALL;
    end else if (hi6 == 6'h0B || hi6 == 6'h13 || hi6 == 6'h0F || hi6 == 6'h12) begin
        // RULE14 RULE20 skip variants: extra cycle on skip
        next_cls = `CLS_SKIP;
        next_cycles = 2'h2;
    end else if (hi7 >= 7'h30 && hi7 <= 7'h33) begin
        // RULE15 compare and test skip
        next_cls = `CLS_SKIP;
        next_cycles = 2'h2;
    end else if (hi6 == 6'h0D || hi6 == 6'h0C) begin
        // RULE16 carry rotates
        next_cls = `CLS_ALU;
        next_flags = `FL_CZN;
    end else if (hi6 == 6'h11 || hi6 == 6'h10) begin
        next_cls = `CLS_ALU;
        next_flags = `FL_ZN;
    end else if (hi6 == 6'h0E) begin
        next_cls = `CLS_ALU;
    end
    // RULE2 destination bit
    if (next_cls == `CLS_ALU || next_cls == `CLS_SKIP) begin
        next_dest = insn[9] && (hi6 < 6'h18);
        next_rmw = next_dest;
    end
    // RULE18 port rewrite reads pins
    if (next_rmw && next_addr >= `PORT_BASE_ADDR && next_addr <= `PORT_TOP_ADDR) begin
        next_operand = port_pins;
    end
end

////////////////////////////////////////////////////////////////////////////////
// execute and registers
wire [15:0] product = acc * insn[7:0];

always @(posedge ref_clk) begin
    if (rst) begin
        insn <= 16'h0000;
        ctrl <= 8'h00;
        pc <= 21'h000000;
        insn_go <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 5'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        bvalid <= 1'b0;
        bresp <= `AXI_OKAY;
        rvalid <= 1'b0;
        rresp <= `AXI_OKAY;
        rdata <= 32'h00000000;
        cls <= `CLS_NOP;
        op6 <= 6'h00;
        dest_file <= 1'b0;
        bank_sel <= 1'b0;
        file_addr <= 12'h000;
        operand <= 8'h00;
        target <= 21'h000000;
        flag_mask <= `FL_NONE;
        bit_pos <= 3'h0;
        fast_mode <= 1'b0;
        cycles <= 2'h0;
        rmw_port <= 1'b0;
        second_pending <= 1'b0;
        move_src <= 12'h000;
        prod_hi <= 8'h00;
        prod_lo <= 8'h00;
        acc <= 8'h00;
        prescaler_clear <= 1'b0;
    end else begin
        prescaler_clear <= 1'b0;
        insn_go <= 1'b0;
        if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end
        if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= `AXI_OKAY;
            case (aw_addr)
                `REG_INSN: begin
                    if (w_strb[0]) insn[7:0] <= w_data[7:0];
                    if (w_strb[1]) insn[15:8] <= w_data[15:8];
                    insn_go <= 1'b1;
                end
                `REG_CTRL: begin
                    if (w_strb[0]) ctrl <= w_data[7:0];
                end
                `REG_PC: begin
                    if (w_strb[0]) pc[7:0] <= w_data[7:0];
                    if (w_strb[1]) pc[15:8] <= w_data[15:8];
                    if (w_strb[2]) pc[20:16] <= w_data[20:16];
                end
                `REG_OPERAND: begin
                    if (w_strb[0]) acc <= w_data[7:0];
                end
                default: begin
                    bresp <= `AXI_SLVERR;
                end
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
        if (insn_go) begin
            cls <= next_cls;
            op6 <= hi6;
            dest_file <= next_dest;
            bank_sel <= insn[8];
            file_addr <= next_addr;
            operand <= next_operand;
            flag_mask <= next_flags;
            bit_pos <= insn[11:9];
            fast_mode <= (next_cls == `CLS_CALL) && insn[8];
            cycles <= next_cycles;
            rmw_port <= next_rmw;
            second_pending <= (top == `PREFIX_MOVE && !second_pending) ||
                ((next_cls == `CLS_CALL || next_cls == `CLS_JUMP) && !second_pending);
            if (top == `PREFIX_MOVE && !second_pending) begin
                move_src <= insn[11:0];
            end
            if (second_pending && cls != `CLS_SECOND) begin
                // RULE7 upper twelve target bits
                target <= {1'b0, insn[11:0], target[7:0]};
                cls <= cls;
                cycles <= 2'h2;
            end else begin
                target <= next_target;
            end
            if (next_cls == `CLS_MUL) begin
                // RULE23 product split
                prod_hi <= product[15:8];
                prod_lo <= product[7:0];
            end
            // RULE19 timer write clears prescaler
            if (next_addr == `TIMER_ZERO_ADDR && !ctrl[`CTRL_PSA_BIT] &&
                (next_dest || next_cls == `CLS_BIT || hi7 >= 7'h34)) begin
                prescaler_clear <= 1'b1;
            end
            pc <= pc + 21'h2;
        end
        if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `AXI_OKAY;
            case (araddr)
                `REG_INSN: rdata <= {16'h0000, insn};
                `REG_CTRL: rdata <= {24'h000000, ctrl};
                `REG_PC: rdata <= {11'h000, pc};
                `REG_DECODE: rdata <= {cls, op6, dest_file, bank_sel, flag_mask, bit_pos,
                    fast_mode, cycles, rmw_port, second_pending, 7'h00};
                `REG_FILE_ADDR: rdata <= {8'h00, move_src, file_addr};
                `REG_OPERAND: rdata <= {8'h00, prod_hi, prod_lo, operand};
                `REG_TARGET: rdata <= {11'h000, target};
                `REG_STATUS: rdata <= {24'h000000, acc};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= `AXI_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ### sim/prog_store.sv
// program memory model: a short image of corner instruction words
`timescale 1ns/1ps
`default_nettype none
module prog_store (
    input wire logic [3:0] idx,
    output logic [15:0] word
);
    logic [15:0] image [11] = '{16'hEF34, 16'hF567, 16'hED12, 16'hFABC, 16'hC123, 16'hF456,
        16'hF0AA, 16'hD3FF, 16'hE280, 16'h0E5A, 16'h8B45};
    // past the image the bus shows a shifting pattern, never the last word
    assign word = (idx < 4'hB) ? image[idx] : {4'hF, idx, 8'hA5};
endmodule
`default_nettype wire

// ### sim/op_decoder_properties.sv
// concurrent checks on the decoder's bus and prescaler ports
`timescale 1ns/1ps
`default_nettype none
module op_decoder_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic prescaler_clear
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_write_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    a_read_latency: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_latency: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");
    a_resp_code: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
        else $error("bad write response code");
    a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
        else $error("prescaler clear longer than one cycle");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !bvalid && !rvalid)
        else $error("response active after reset");
endmodule
bind op_decoder op_decoder_properties op_decoder_properties_inst (.ref_clk(ref_clk),
    .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .prescaler_clear(prescaler_clear));
`default_nettype wire

// ### sim/tb_op_decoder.sv
// random and corner decode checks over the register bus
`timescale 1ns/1ps
`default_nettype none
module tb_op_decoder;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] port_pins = 8'h00;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, r, m, x;
    logic [3:0] wstrb = 4'hF, idx = 4'h0, bp, c;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, prescaler_clear;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] pw, w, e;
    int failures = 0, check_count = 0, cyc = 0, pulses = 0, p0;
    // {opcode bits 14:9, has destination bit, flag mask, class}
    logic [15:0] tbl [24] = '{16'h4BF1, 16'h43F1, 16'h2A51, 16'h2251, 16'h3A51, 16'hBBF1,
        16'hB3F1, 16'hABF1, 16'h53F1, 16'h0BF1, 16'h5A02, 16'h9A02, 16'h7A02, 16'h9202,
        16'h6B51, 16'h6351, 16'h8A51, 16'h8251, 16'h7201, 16'hC402, 16'hC802, 16'hC002,
        16'hCC02, 16'h040A};
    // class per image word, F where a second word leaves it open
    logic [43:0] ecls = 44'h6F7FB3B8954;

    always #12.5 ref_clk = ~ref_clk;
    op_decoder op_decoder_inst (.ref_clk(ref_clk), .rst(rst), .port_pins(port_pins),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .prescaler_clear(prescaler_clear));
    prog_store prog_store_inst (.idx(idx), .word(pw));

    always @(posedge ref_clk) begin
        cyc++;
        if (prescaler_clear === 1'b1) pulses++;
        if (cyc > 10000) begin
            failures++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ready is raised late at random so the hold checks see waiting answers
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        int dly;
        logic hs;
        n = 0;
        dly = $urandom % 3;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (dly == 0);
        do begin
            @(posedge ref_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            hs = bvalid && bready;
            if (!hs) bready <= (n >= dly);
        end while (!hs);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] s);
        int n;
        int dly;
        logic hs;
        n = 0;
        dly = $urandom % 3;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (dly == 0);
        do begin
            @(posedge ref_clk);
            n++;
            if (arready) arvalid <= 1'b0;
            hs = rvalid && rready;
            d = rdata;
            s = rresp;
            if (!hs) rready <= (n >= dly);
        end while (!hs);
        rready <= 1'b0;
    endtask

    task automatic dec(input logic [15:0] word);
        wr(5'h00, {16'h0, word});
        repeat (2) @(posedge ref_clk);
        rd(5'h0C, r, rs);
    endtask

    function automatic logic [11:0] faddr(input logic a, input logic [7:0] f, input logic [3:0] b);
        faddr = a ? {b, f} : (f < 8'h60 ? {4'h0, f} : {4'hF, f});
    endfunction

    function automatic logic [15:0] prod(input logic [7:0] a, input logic [7:0] b);
        prod = a * b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(29587);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 96; i++) begin
            e = tbl[i % 24];
            bp = 4'($urandom);
            port_pins <= 8'($urandom);
            wr(5'h04, {27'h0, 1'b1, bp});
            w = {1'b0, e[15:10], 9'h0} | (16'($urandom) & (e[9] ? 16'h03FF : 16'h01FF));
            dec(w);
            m = e[9] ? 32'hFFFF8000 : 32'hFFDF8000;
            x = {e[3:0], w[15:10], w[9], w[8], e[8:4], 15'h0};
            chk("decode fields", r & m, x & m);
            rd(5'h10, r, rs);
            chk("file address", {20'h0, r[11:0]}, {20'h0, faddr(w[8], w[7:0], bp)});
        end
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            idx = 4'(i);
            // let the image word settle before it is captured as an argument
            @(posedge ref_clk);
            dec(pw);
            c = ecls[4*(10-i) +: 4];
            if (c != 4'hF) chk("class", {28'h0, r[31:28]}, {28'h0, c});
            if (i == 2) chk("fast bit", {31'h0, r[11]}, 32'h1);
            if (i == 7) chk("jump cycles", {30'h0, r[10:9]}, 32'h2);
            if (i == 10) chk("bit position", {29'h0, r[14:12]}, 32'h5);
            if (i == 1 || i == 3 || i == 5 || i == 9) begin
                rd(i == 9 ? 5'h14 : (i == 5 ? 5'h10 : 5'h18), r, rs);
                x = i == 1 ? 32'h56734 : i == 3 ? 32'hABC12 : i == 5 ? 32'h123456 : 32'h5A;
                chk("payload", r & (i == 9 ? 32'hFF : 32'hFFFFFF), x);
            end
        end
        // pins differ from both address bytes so a wrong operand source shows
        port_pins <= 8'h3C;
        dec(16'h2682);
        chk("port read back", {31'h0, r[8]}, 32'h1);
        rd(5'h14, r, rs);
        chk("port operand", {24'h0, r[7:0]}, 32'h3C);
        dec(16'h2690);
        chk("plain read back", {31'h0, r[8]}, 32'h1);
        rd(5'h14, r, rs);
        chk("plain operand", {24'h0, r[7:0]}, 32'h90);
        for (int k = 0; k < 4; k++) begin
            wr(5'h04, k == 1 ? 32'h1F : 32'h0F);
            p0 = pulses;
            dec(k == 2 ? 16'h24D6 : (k == 3 ? 16'h27D6 : 16'h26D6));
            chk("prescaler clears", pulses - p0, (k == 1 || k == 2) ? 0 : 1);
        end
        wr(5'h14, 32'h000000C7);
        dec(16'h0253);
        rd(5'h14, r, rs);
        chk("product", {16'h0, r[23:8]}, {16'h0, prod(8'hC7, 8'h53)});
        rd(5'h06, r, rs);
        chk("unmapped response", {30'h0, rs}, 32'h2);
        chk("unmapped data", r, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
